// ===== shared/sdc_pkg.sv
// package: constants and types for the stepper control and diagnostics block
package sdc_pkg;
   // clock rate and timing
   localparam int CLK_MHZ = 200;
   localparam int OPEN_COIL_MS = 200;
   localparam int OPEN_COIL_CYCLES = OPEN_COIL_MS * 1000 * CLK_MHZ;
   // hard reset pin minimum hold, in ns
   localparam int HARD_RESET_NS = 100;
   localparam int HARD_RESET_CYCLES = (HARD_RESET_NS * CLK_MHZ + 999) / 1000;
   // coil amplitude field
   localparam int AMP_W = 5;
   localparam int CUR_W = 10;
   // range boundaries: first index of ranges 1, 2 and 3
   localparam logic [4:0] RANGE1_FIRST = 5'h09;
   localparam logic [4:0] RANGE2_FIRST = 5'h10;
   localparam logic [4:0] RANGE3_FIRST = 5'h17;
   // reset values
   localparam logic [4:0] AMP_RESET = 5'h00;
   localparam logic [5:0] FLAGS_RESET = 6'h00;
   // back-emf gain codes: 0 halves, 1 quarters
   localparam int BEMF_W = 8;

   // fault comparator inputs, all asynchronous
   typedef struct packed {
      logic temp_warn;
      logic temp_shutdown;
      logic [3:0] ovc_x;
      logic [3:0] ovc_y;
      logic pump_low;
   } sdc_faults_t;

   // latched status as seen by the serial side
   typedef struct packed {
      logic thermal_warning_flag;
      logic thermal_shutdown_flag;
      logic [3:0] coil_x_overcurrent_flags;
      logic [3:0] coil_y_overcurrent_flags;
      logic coil_x_disconnect_flag;
      logic coil_y_disconnect_flag;
      logic pump_failure_flag;
   } sdc_status_t;

   // driver enable state
   typedef enum logic [1:0] {
      SDC_RUN = 2'b00,
      SDC_SLEEP = 2'b01,
      SDC_FAULT = 2'b10
   } sdc_drv_t;
endpackage : sdc_pkg

// ===== hdl/sdc_sync.sv
// module: two-stage synchroniser, one per bit
module sdc_sync #(
   parameter int W = 11
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   // first stage is read only by the second
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         meta <= '0;
         q <= '0;
      end
      else
      begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : sdc_sync

// ===== hdl/sdc_open_timer.sv
// module: full-duty watchdog for one coil, flags an open coil
module sdc_open_timer #(
   parameter int LIMIT = 40000000
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // duty observation and clear
   input wire logic full_duty,
   input wire logic clear,
   // result
   output logic open_flag
);
   localparam int CW = $clog2(LIMIT + 1);
   logic [CW-1:0] count;
   wire expired = (count == CW'(LIMIT));

   // count consecutive full-duty cycles; set wins over clear
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         count <= '0;
         open_flag <= 1'b0;
      end
      else
      begin
         if (!full_duty)
            count <= '0;
         else if (!expired)
            count <= count + CW'(1);
         if (expired)
            open_flag <= 1'b1;
         else if (clear)
            open_flag <= 1'b0;
      end
   end
endmodule : sdc_open_timer

// ===== hdl/sdc_ctrl.sv
// module: control and diagnostics core of the stepper driver
// Behaviour
// R1: new amplitude index applied at start of next pwm period
// R2: index 0..31 decodes to 15..800 mA, four current ranges
// R3: controller should expect false over-current on range crossing
// R4: back-emf sampled at every coil-current zero crossing; code samples only while pwm_sample_hold is high
// R5: transparency bit set follows coil voltage, else held sample
// R6: gain bit scales coil voltage by half or quarter
// R7: thermal warning flag set above warning threshold
// R8: shutdown flag set above shutdown level, drivers high impedance
// R9: shutdown flag clears only when cool and read
// R10: over-current sets per-transistor flag and switches drivers off
// R11: over-current latched, drivers off until controller clears
// R12: controller should not poll status during a short
// R13: full duty longer than 200 ms disables coil, sets open flag
// R14: pump failure flag follows low pump voltage, incl start-up
// R15: fault indicator low when any flag set
// R16: hard reset pin held high resets all registers
// R17: sleep puts drivers high impedance, keeps registers
// R18: controller keeps step and direction still while asleep
// R19: clearing sleep resumes; controller waits for pump start-up
// R20: controller lowers resolution only at shared positions
// R21: device is serial slave only, never starts a transfer
// R22: latched status cleared after being read
// R23: flags and fault output update only while select high
// R24: fault comparators pass two-stage synchroniser first
module sdc_ctrl #(
   parameter int OPEN_LIMIT = sdc_pkg::OPEN_COIL_CYCLES
) (
   // clock and resets
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic hard_reset_pin,
   // configuration bits
   input wire logic [4:0] coil_amplitude_index,
   input wire logic back_emf_transparency_bit,
   input wire logic back_emf_gain_bit,
   input wire logic low_power_request_bit,
   // serial side events
   input wire logic chip_select_n,
   input wire logic status_read,
   // analogue observation
   input wire sdc_pkg::sdc_faults_t faults,
   input wire logic pwm_period_start,
   input wire logic [1:0] full_duty,
   input wire logic [1:0] coil_zero,
   input wire logic pwm_sample_hold,
   input wire logic [7:0] coil_voltage,
   // outputs
   output logic [9:0] coil_peak_ma,
   output logic [1:0] current_range,
   output logic [7:0] back_emf_output,
   output logic [1:0] coil_drive_en,
   output sdc_pkg::sdc_status_t status,
   output logic fault_indicator_n
);
   // R16: pin reset
   logic [7:0] clr_cnt;
   logic clr_reset;
   wire int_rst = rst | clr_reset;
   sdc_pkg::sdc_faults_t fs;
   logic [1:0] open_now;
   logic [4:0] amp_active;
   logic [7:0] held;
   sdc_pkg::sdc_drv_t drv_state;

   // pin counted for minimum hold; release on pin low
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         clr_cnt <= 8'h00;
         clr_reset <= 1'b0;
      end
      else if (!hard_reset_pin)
      begin
         clr_cnt <= 8'h00;
         clr_reset <= 1'b0;
      end
      else if (clr_cnt >= 8'(sdc_pkg::HARD_RESET_CYCLES - 1))
         clr_reset <= 1'b1;
      else
         clr_cnt <= clr_cnt + 8'h01;
   end

   // R24: fault inputs synchronised
   sdc_sync #(
      .W($bits(sdc_pkg::sdc_faults_t))
   ) u_sync (
      .clk_sys(clk_sys),
      .rst(int_rst),
      .d(faults),
      .q(fs)
   );

   // R13: watchdog per coil
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_open
         sdc_open_timer #(
            .LIMIT(OPEN_LIMIT)
         ) u_timer (
            .clk_sys(clk_sys),
            .rst(int_rst),
            .full_duty(full_duty[gi]),
            .clear(status_read),
            .open_flag(open_now[gi])
         );
      end
   endgenerate

   // R2: index to peak current table
   function automatic logic [9:0] amp_to_ma(input logic [4:0] idx);
      logic [9:0] t [32];
      t = '{10'd15, 10'd30, 10'd45, 10'd50, 10'd55, 10'd61, 10'd67, 10'd74,
            10'd82, 10'd91, 10'd100, 10'd110, 10'd122, 10'd135, 10'd149, 10'd164,
            10'd181, 10'd200, 10'd221, 10'd244, 10'd269, 10'd297, 10'd328, 10'd362,
            10'd400, 10'd441, 10'd487, 10'd538, 10'd594, 10'd656, 10'd724, 10'd800};
      return t[idx];
   endfunction : amp_to_ma

   // R2: range decode
   wire [1:0] range_of = (amp_active >= sdc_pkg::RANGE3_FIRST) ? 2'd3 :
                         (amp_active >= sdc_pkg::RANGE2_FIRST) ? 2'd2 :
                         (amp_active >= sdc_pkg::RANGE1_FIRST) ? 2'd1 : 2'd0;

   // R1: amplitude taken at period start
   always_ff @(posedge clk_sys or posedge int_rst)
   begin
      if (int_rst)
      begin
         amp_active <= sdc_pkg::AMP_RESET;
         coil_peak_ma <= 10'd15;
         current_range <= 2'd0;
      end
      else
      begin
         if (pwm_period_start)
            amp_active <= coil_amplitude_index;
         coil_peak_ma <= amp_to_ma(amp_active);
         current_range <= range_of;
      end
   end

   // R6: gain selects halve or quarter
   wire [7:0] scaled = back_emf_gain_bit ? {2'b00, coil_voltage[7:2]} :
                                           {1'b0, coil_voltage[7:1]};
   // R4: sample at zero crossing while hold window open
   wire sample_now = (|coil_zero) & pwm_sample_hold;

   // R5: transparent or held output
   always_ff @(posedge clk_sys or posedge int_rst)
   begin
      if (int_rst)
      begin
         held <= 8'h00;
         back_emf_output <= 8'h00;
      end
      else
      begin
         if (sample_now)
            held <= scaled;
         back_emf_output <= back_emf_transparency_bit ? scaled : held;
      end
   end

   // R21: select and read strobe are inputs only; no transfer starts here
   // R23: updates only while select high; read clears only then too
   wire upd = chip_select_n;
   wire rd = status_read & upd;

   // flag latching; set always beats clear
   always_ff @(posedge clk_sys or posedge int_rst)
   begin
      if (int_rst)
      begin
         status <= '0;
         status.pump_failure_flag <= 1'b1;
      end
      else if (upd)
      begin
         // R7: warning follows comparator, held until read
         status.thermal_warning_flag <= fs.temp_warn | (status.thermal_warning_flag & ~rd);
         // R8: R9: shutdown needs cool and read to clear
         status.thermal_shutdown_flag <= fs.temp_shutdown |
            (status.thermal_shutdown_flag & ~(rd & ~fs.temp_warn));
         // R10: R11: R22: latched over-current
         status.coil_x_overcurrent_flags <= fs.ovc_x |
            (status.coil_x_overcurrent_flags & {4{~rd}});
         status.coil_y_overcurrent_flags <= fs.ovc_y |
            (status.coil_y_overcurrent_flags & {4{~rd}});
         // R13: open coil flags
         status.coil_x_disconnect_flag <= open_now[0];
         status.coil_y_disconnect_flag <= open_now[1];
         // R14: pump flag tracks comparator
         status.pump_failure_flag <= fs.pump_low;
      end
   end

   // R15: any flag pulls indicator low
   wire any_flag = |status;
   always_ff @(posedge clk_sys or posedge int_rst)
   begin
      if (int_rst)
         fault_indicator_n <= 1'b0;
      else if (upd)
         fault_indicator_n <= ~any_flag;
   end

   // driver state: fault beats sleep
   wire ovc_any = (|status.coil_x_overcurrent_flags) | (|status.coil_y_overcurrent_flags);
   wire hard_fault = status.thermal_shutdown_flag | ovc_any;
   wire sdc_pkg::sdc_drv_t next_drv = hard_fault ? sdc_pkg::SDC_FAULT :
                                      low_power_request_bit ? sdc_pkg::SDC_SLEEP :
                                      sdc_pkg::SDC_RUN;

   // R8: R10: R17: R19: driver enables; open coil disables that coil only
   always_ff @(posedge clk_sys or posedge int_rst)
   begin
      if (int_rst)
      begin
         drv_state <= sdc_pkg::SDC_RUN;
         coil_drive_en <= 2'b00;
      end
      else
      begin
         drv_state <= next_drv;
         unique case (next_drv)
            sdc_pkg::SDC_RUN:
               coil_drive_en <= ~{status.coil_y_disconnect_flag, status.coil_x_disconnect_flag}
                                & ~open_now;
            sdc_pkg::SDC_SLEEP:
               coil_drive_en <= 2'b00;
            sdc_pkg::SDC_FAULT:
               coil_drive_en <= 2'b00;
            default:
               coil_drive_en <= 2'b00;
         endcase
      end
   end

   // edges since reset release, saturating; lets the sync check skip reset history
   logic [1:0] since_rst;
   always_ff @(posedge clk_sys or posedge int_rst)
   begin
      if (int_rst)
         since_rst <= 2'b00;
      else if (since_rst != 2'b10)
         since_rst <= since_rst + 2'b01;
   end

   // assertions
   a_shutdown_off: assert property (@(posedge clk_sys) disable iff (int_rst)
      status.thermal_shutdown_flag |=> coil_drive_en == 2'b00) // R8
      else $error("drivers on during thermal shutdown");
   a_ovc_drivers_off: assert property (@(posedge clk_sys) disable iff (int_rst)
      ovc_any |=> coil_drive_en == 2'b00) // R10
      else $error("drivers on during over-current");
   a_ovc_latched: assert property (@(posedge clk_sys) disable iff (int_rst)
      ($fell(|status.coil_x_overcurrent_flags)) |-> $past(rd)) // R11
      else $error("over-current cleared without read");
   a_tsd_clear_cond: assert property (@(posedge clk_sys) disable iff (int_rst)
      $fell(status.thermal_shutdown_flag) |-> $past(rd) && !$past(fs.temp_warn)) // R9
      else $error("shutdown cleared while warm or unread");
   a_sleep_hiz: assert property (@(posedge clk_sys) disable iff (int_rst)
      low_power_request_bit |=> coil_drive_en == 2'b00) // R17
      else $error("drivers on in sleep");
   a_fault_pin: assert property (@(posedge clk_sys) disable iff (int_rst)
      (upd && any_flag) |=> !fault_indicator_n) // R15
      else $error("fault indicator not low");
   a_cs_hold: assert property (@(posedge clk_sys) disable iff (int_rst)
      !chip_select_n |=> $stable(status)) // R23
      else $error("status changed while selected");
   a_amp_period: assert property (@(posedge clk_sys) disable iff (int_rst)
      pwm_period_start |=> amp_active == $past(coil_amplitude_index)) // R1
      else $error("amplitude not taken at period start");
   a_amp_hold: assert property (@(posedge clk_sys) disable iff (int_rst)
      !pwm_period_start |=> $stable(amp_active)) // R1
      else $error("amplitude changed mid period");
   a_peak_top: assert property (@(posedge clk_sys) disable iff (int_rst)
      amp_active == 5'd31 |=> coil_peak_ma == 10'd800 && current_range == 2'd3) // R2
      else $error("peak current decode wrong");
   a_bemf_hold: assert property (@(posedge clk_sys) disable iff (int_rst)
      sample_now |=> held == $past(scaled)) // R4
      else $error("back-emf not sampled");
   a_bemf_transp: assert property (@(posedge clk_sys) disable iff (int_rst)
      back_emf_transparency_bit |=> back_emf_output == $past(scaled)) // R5
      else $error("transparent output wrong");
   a_warn_set: assert property (@(posedge clk_sys) disable iff (int_rst)
      (upd && fs.temp_warn) |=> status.thermal_warning_flag) // R7
      else $error("warning flag not set");
   a_pump_flag: assert property (@(posedge clk_sys) disable iff (int_rst)
      (upd && fs.pump_low) |=> status.pump_failure_flag) // R14
      else $error("pump flag not set");
   a_ovcy_latched: assert property (@(posedge clk_sys) disable iff (int_rst)
      ($fell(|status.coil_y_overcurrent_flags)) |-> $past(rd)) // R11
      else $error("coil y over-current cleared without read");
   a_open_x_off: assert property (@(posedge clk_sys) disable iff (int_rst)
      open_now[0] |=> !coil_drive_en[0]) // R13
      else $error("coil x driven while open");
   a_open_y_off: assert property (@(posedge clk_sys) disable iff (int_rst)
      open_now[1] |=> !coil_drive_en[1]) // R13
      else $error("coil y driven while open");
   a_warn_clear: assert property (@(posedge clk_sys) disable iff (int_rst)
      $fell(status.thermal_warning_flag) |-> $past(rd)) // R22
      else $error("warning cleared without read");
   a_fault_clear: assert property (@(posedge clk_sys) disable iff (int_rst)
      (upd && !any_flag) |=> fault_indicator_n) // R15
      else $error("fault indicator low with no flag");
   a_range_low: assert property (@(posedge clk_sys) disable iff (int_rst)
      amp_active == 5'd0 |=> coil_peak_ma == 10'd15 && current_range == 2'd0) // R2
      else $error("lowest peak current decode wrong");
   a_bemf_held: assert property (@(posedge clk_sys) disable iff (int_rst)
      !back_emf_transparency_bit |=> back_emf_output == $past(held)) // R5
      else $error("held output wrong");
   a_sleep_keep: assert property (@(posedge clk_sys) disable iff (int_rst)
      (low_power_request_bit && !pwm_period_start) |=> $stable(amp_active)) // R17
      else $error("amplitude lost in sleep");
   a_sync_delay: assert property (@(posedge clk_sys) disable iff (int_rst)
      since_rst == 2'b10 |-> fs == $past(faults, 2)) // R24
      else $error("fault synchroniser delay wrong");

   // pin reset checks run on the power-on reset only, as the pin drives int_rst
   a_pin_assert: assert property (@(posedge clk_sys) disable iff (rst)
      (hard_reset_pin && clr_cnt == 8'(sdc_pkg::HARD_RESET_CYCLES - 1)) |=> clr_reset) // R16
      else $error("pin reset not asserted");
   a_pin_release: assert property (@(posedge clk_sys) disable iff (rst)
      !hard_reset_pin |=> !clr_reset) // R16
      else $error("pin reset not released");

   c_shutdown: cover property (@(posedge clk_sys) $rose(status.thermal_shutdown_flag));
   c_ovc_clear: cover property (@(posedge clk_sys) $fell(ovc_any));
   c_sleep_wake: cover property (@(posedge clk_sys) $fell(low_power_request_bit));
   c_open_coil: cover property (@(posedge clk_sys) $rose(open_now[0]));
   c_pin_reset: cover property (@(posedge clk_sys) $rose(clr_reset));
endmodule : sdc_ctrl

// ===== verification/sdc_host_model.sv
// host model: external controller that selects the block and reads status
module sdc_host_model (
   // clock
   input wire logic clk_sys,
   // serial side events
   output logic chip_select_n,
   output logic status_read
);
   timeunit 1ns;
   timeprecision 100ps;

   // idle with select high, so status keeps updating between transfers
   initial
   begin
      chip_select_n = 1'b1;
      status_read = 1'b0;
   end

   // every transfer starts here, never at the block
   // one read per call, no polling during a short
   task automatic read_status();
      @(negedge clk_sys) chip_select_n = 1'b0;
      repeat (8) @(negedge clk_sys);
      // select raised together with the read strobe, as the block needs
      chip_select_n = 1'b1;
      status_read = 1'b1;
      @(negedge clk_sys) status_read = 1'b0;
   endtask : read_status

   // no step, direction or resolution traffic from this model
   task automatic hold_select(input logic lvl);
      @(negedge clk_sys) chip_select_n = lvl;
   endtask : hold_select
endmodule : sdc_host_model

// ===== verification/sdc_ctrl_tb.sv
// testbench: stepper control and diagnostics block
module sdc_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int LIMIT = 50;
   localparam int MAX_CYC = 4000;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic hard_reset_pin = 1'b0;
   logic [4:0] amp = 5'h00;
   logic transp = 1'b0;
   logic gain = 1'b0;
   logic sleep = 1'b0;
   logic chip_select_n;
   logic status_read;
   sdc_pkg::sdc_faults_t faults = 11'h001;
   logic period = 1'b0;
   logic [1:0] full_duty = 2'b00;
   logic [1:0] coil_zero = 2'b00;
   logic hold = 1'b0;
   logic [7:0] volt = 8'h00;
   logic [9:0] peak;
   logic [1:0] rng;
   logic [7:0] bemf;
   logic [1:0] drv;
   sdc_pkg::sdc_status_t status;
   logic fault_n;
   int n_mismatch = 0;
   int checks = 0;
   int cycles = 0;
   int ma_tab[32] = '{15, 30, 45, 50, 55, 61, 67, 74, 82, 91, 100, 110, 122, 135, 149, 164,
      181, 200, 221, 244, 269, 297, 328, 362, 400, 441, 487, 538, 594, 656, 724, 800};

   // 200 MHz system clock
   always #2.5 clk_sys = ~clk_sys;

   sdc_ctrl #(.OPEN_LIMIT(LIMIT)) dut_u (.clk_sys(clk_sys), .rst(rst),
      .hard_reset_pin(hard_reset_pin), .coil_amplitude_index(amp),
      .back_emf_transparency_bit(transp), .back_emf_gain_bit(gain),
      .low_power_request_bit(sleep), .chip_select_n(chip_select_n),
      .status_read(status_read), .faults(faults), .pwm_period_start(period),
      .full_duty(full_duty), .coil_zero(coil_zero), .pwm_sample_hold(hold),
      .coil_voltage(volt), .coil_peak_ma(peak), .current_range(rng),
      .back_emf_output(bemf), .coil_drive_en(drv), .status(status),
      .fault_indicator_n(fault_n));

   sdc_host_model host_u (.clk_sys(clk_sys), .chip_select_n(chip_select_n),
      .status_read(status_read));

   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : tick

   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk_val

   // one-cycle period start, then let the two-stage update land
   task automatic new_period();
      period = 1'b1;
      tick(1);
      period = 1'b0;
      tick(3);
   endtask : new_period

   task automatic wrap_up();
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : wrap_up

   // cycle ceiling; the sequence needs well under a thousand cycles
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == MAX_CYC)
      begin
         n_mismatch++;
         $display("wrong value at %0t: run did not finish", $time);
         wrap_up();
      end
   end

   // main sequence
   initial
   begin
      tick(10);
      chk_val({3'b000, status}, 16'h0001, "reset status");
      chk_val({15'h0000, fault_n}, 16'h0000, "reset fault");
      chk_val({6'h00, peak}, 16'h000F, "reset peak");
      rst = 1'b0;
      tick(5);
      chk_val({3'b000, status}, 16'h0001, "pump startup");
      faults.pump_low = 1'b0;
      tick(5);
      chk_val({3'b000, status}, 16'h0000, "pump ok");
      chk_val({15'h0000, fault_n}, 16'h0001, "no fault");
      chk_val({14'h0000, drv}, 16'h0003, "drivers on");
      // every amplitude index, with its range
      for (int i = 0; i < 32; i++)
      begin
         amp = 5'(i);
         new_period();
         chk_val({6'h00, peak}, 16'(ma_tab[i]), "peak");
         chk_val({14'h0000, rng}, 16'(i < 9 ? 0 : i < 16 ? 1 : i < 23 ? 2 : 3), "range");
      end
      amp = 5'h10;
      tick(4);
      chk_val({6'h00, peak}, 16'h0320, "held to period");
      new_period();
      chk_val({6'h00, peak}, 16'h00B5, "new period");
      // sleep keeps registers, drivers released
      sleep = 1'b1;
      tick(4);
      chk_val({14'h0000, drv}, 16'h0000, "sleep drivers");
      chk_val({6'h00, peak}, 16'h00B5, "sleep keeps");
      sleep = 1'b0;
      tick(4);
      chk_val({14'h0000, drv}, 16'h0003, "wake drivers");
      // back-emf transparent, then held samples on each coil
      transp = 1'b1;
      volt = 8'hA4;
      tick(4);
      chk_val({8'h00, bemf}, 16'h0052, "bemf half");
      gain = 1'b1;
      tick(4);
      chk_val({8'h00, bemf}, 16'h0029, "bemf quarter");
      transp = 1'b0;
      coil_zero = 2'b01;
      hold = 1'b1;
      volt = 8'h80;
      tick(2);
      coil_zero = 2'b00;
      hold = 1'b0;
      volt = 8'hFF;
      tick(4);
      chk_val({8'h00, bemf}, 16'h0020, "bemf held x");
      gain = 1'b0;
      coil_zero = 2'b10;
      hold = 1'b1;
      volt = 8'h60;
      tick(2);
      coil_zero = 2'b00;
      hold = 1'b0;
      volt = 8'h11;
      tick(4);
      chk_val({8'h00, bemf}, 16'h0030, "bemf held y");
      // warning arrives while selected: frozen until select rises
      host_u.hold_select(1'b0);
      faults.temp_warn = 1'b1;
      tick(6);
      chk_val({3'b000, status}, 16'h0000, "frozen");
      host_u.hold_select(1'b1);
      tick(5);
      chk_val({3'b000, status}, 16'h1000, "warning");
      chk_val({15'h0000, fault_n}, 16'h0000, "warn fault");
      faults.temp_warn = 1'b0;
      tick(5);
      chk_val({3'b000, status}, 16'h1000, "warn latched");
      host_u.read_status();
      tick(3);
      chk_val({3'b000, status}, 16'h0000, "warn read");
      // shutdown clears only when cool and read
      faults.temp_warn = 1'b1;
      faults.temp_shutdown = 1'b1;
      tick(5);
      chk_val({3'b000, status}, 16'h1800, "shutdown");
      chk_val({14'h0000, drv}, 16'h0000, "shutdown off");
      faults.temp_shutdown = 1'b0;
      host_u.read_status();
      tick(3);
      chk_val({3'b000, status}, 16'h1800, "read warm");
      faults.temp_warn = 1'b0;
      tick(3);
      host_u.read_status();
      tick(3);
      chk_val({3'b000, status}, 16'h0000, "read cool");
      // over-current on two transistors, latched until read
      faults.ovc_x = 4'h1;
      faults.ovc_y = 4'h8;
      tick(5);
      chk_val({3'b000, status}, 16'h00C0, "ovc flags");
      chk_val({14'h0000, drv}, 16'h0000, "ovc off");
      faults.ovc_x = 4'h0;
      faults.ovc_y = 4'h0;
      tick(5);
      chk_val({3'b000, status}, 16'h00C0, "ovc latched");
      chk_val({14'h0000, drv}, 16'h0000, "ovc stays off");
      host_u.read_status();
      tick(3);
      chk_val({14'h0000, drv}, 16'h0003, "ovc cleared");
      // full duty on coil x: nothing before the limit, open after
      full_duty = 2'b01;
      tick(LIMIT - 4);
      chk_val({3'b000, status}, 16'h0000, "before limit");
      tick(10);
      chk_val({3'b000, status}, 16'h0004, "open x");
      chk_val({14'h0000, drv}, 16'h0002, "open x off");
      full_duty = 2'b00;
      host_u.read_status();
      tick(3);
      chk_val({14'h0000, drv}, 16'h0003, "open cleared");
      // pump low later in the run
      faults.pump_low = 1'b1;
      tick(5);
      chk_val({15'h0000, fault_n}, 16'h0000, "pump fault");
      faults.pump_low = 1'b0;
      tick(5);
      chk_val({3'b000, status}, 16'h0000, "pump follows");
      // hard reset pin clears the stored amplitude
      hard_reset_pin = 1'b1;
      tick(22);
      chk_val({6'h00, peak}, 16'h000F, "pin reset");
      hard_reset_pin = 1'b0;
      tick(6);
      chk_val({6'h00, peak}, 16'h000F, "after pin");
      chk_val({3'b000, status}, 16'h0000, "after pin st");
      wrap_up();
   end
endmodule : sdc_ctrl_tb
